// File: prr_entropy.sv
// free-running 16-bit galois lfsr feeding the random word
`timescale 1ns/10ps
module prr_entropy import prr_pkg::*; (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // random word
    output logic      [REG_W-1:0] rnd
);
    typedef struct packed {
        logic [REG_W-1:0] lfsr;
    } prr_ent_state_t;

    prr_ent_state_t r_reg;
    prr_ent_state_t r_next;

    // steps every clock so consecutive reads are far apart in the sequence;
    // pseudo-random only, not a true noise source
    always_comb begin
        r_next      = r_reg;
        r_next.lfsr = (r_reg.lfsr >> 1) ^ (r_reg.lfsr[0] ? LFSR_TAPS : '0);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg.lfsr <= LFSR_SEED; // nonzero, the lfsr would lock at zero
        end else begin
            r_reg <= r_next;
        end
    end

    assign rnd = r_reg.lfsr;
endmodule // prr_entropy

// File: prr_pkg.sv
// constants and types shared by the extended id / interrupt / ring switchover register group
package prr_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int             REG_W     = 16;
    localparam int             ADDR_W    = 8;
    localparam logic [ADDR_W-1:0] IDX_CAP   = 8'h12;
    localparam logic [ADDR_W-1:0] IDX_ENT   = 8'h13;
    localparam logic [ADDR_W-1:0] IDX_IEN   = 8'h1C;
    localparam logic [ADDR_W-1:0] IDX_IPEND = 8'h1D;
    localparam logic [ADDR_W-1:0] IDX_RING  = 8'h1E;

    // ------------------------------------------------------------
    // capability word fields
    // ------------------------------------------------------------
    localparam int CAP_IND    = 15;
    localparam int CAP_QUAD   = 14;
    localparam int CAP_PTP    = 13;
    localparam int CAP_SEC    = 12;
    localparam int CAP_RSV    = 11;
    localparam int CAP_DUAL   = 10;
    localparam int CAP_HIPREC = 9;
    localparam int CAP_KEY256 = 8;

    // ------------------------------------------------------------
    // interrupt source positions
    // ------------------------------------------------------------
    localparam int IRQ_N         = 11;
    localparam int IRQ_EEE_WAKE  = 0;
    localparam int IRQ_EEE_SLEEP = 1;
    localparam int IRQ_EEE_QUIET = 2;
    localparam int IRQ_EEE_LFAIL = 3;
    localparam int IRQ_RING_DONE = 4;
    localparam int IRQ_SEC_HOST  = 5;
    localparam int IRQ_SEC_LINE  = 6;
    localparam int IRQ_SEC_FCBUF = 7;
    localparam int IRQ_SEC_ING   = 8;
    localparam int IRQ_SEC_EGR   = 9;
    localparam int IRQ_MEM_RING  = 10;
    localparam logic [IRQ_N-1:0] IRQ_RESET = 11'h000;

    // ------------------------------------------------------------
    // ring switchover word fields and status codes
    // ------------------------------------------------------------
    localparam int RING_START_EN = 15;
    localparam int RING_ADV      = 14;
    localparam int RING_LP_ADV   = 13;
    localparam int RING_FORCE    = 12;
    localparam int RING_ST_HI    = 5;
    localparam int RING_ST_LO    = 4;
    localparam int RING_GO       = 0;
    localparam logic [1:0] ST_SLAVE  = 2'h0;
    localparam logic [1:0] ST_S2M    = 2'h2;
    localparam logic [1:0] ST_MASTER = 2'h3;
    localparam logic [1:0] ST_M2S    = 2'h1;

    // ------------------------------------------------------------
    // timing: switchover hand-off time at 100 ns clock
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 100;
    localparam int SWITCH_TIME_NS = 1000;
    localparam int SWITCH_CYCLES  = (SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // entropy generator constants
    // ------------------------------------------------------------
    localparam logic [REG_W-1:0] LFSR_SEED = 16'hACE1;
    localparam logic [REG_W-1:0] LFSR_TAPS = 16'hB400;

    typedef enum logic [1:0] {
        RING_SLAVE,
        RING_S2M,
        RING_MASTER,
        RING_M2S
    } prr_ring_t;

    // encode a ring state into its two status bits
    function automatic logic [1:0] prr_ring_code(input prr_ring_t s);
        case (s)
            RING_SLAVE:  prr_ring_code = ST_SLAVE;
            RING_S2M:    prr_ring_code = ST_S2M;
            RING_MASTER: prr_ring_code = ST_MASTER;
            RING_M2S:    prr_ring_code = ST_M2S;
            default:     prr_ring_code = ST_SLAVE;
        endcase
    endfunction

endpackage

// File: prr_regs.sv
// apb register group: capability word, random word, extended irq enable/pending, ring switchover
`timescale 1ns/10ps
module prr_regs import prr_pkg::*; #(
    parameter bit         CAP_IND_P    = 1'b1,
    parameter bit         CAP_QUAD_P   = 1'b1,
    parameter bit         CAP_PTP_P    = 1'b1,
    parameter bit         CAP_SEC_P    = 1'b1,
    parameter bit         CAP_DUAL_P   = 1'b1,
    parameter bit         CAP_HIPREC_P = 1'b0,
    parameter bit         CAP_KEY256_P = 1'b1,
    parameter logic [7:0] VARIANT_BCD  = 8'h01 // arbitrary suffix value
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // interrupt source events, one-cycle pulses on pclk
    input  wire logic [IRQ_N-1:0]  irq_event,
    // line-side status levels, asynchronous
    input  wire logic              link_up,
    input  wire logic              aneg_master,
    input  wire logic              link_partner_adv,
    // ring switchover status out
    output logic      [1:0]        timing_role,
    output logic                   ring_switch_busy
);

    // ------------------------------------------------------------
    // constants and elaboration checks
    // ------------------------------------------------------------
    localparam int CNT_W     = $clog2(SWITCH_CYCLES + 1);
    // cycles from the first transit state to the steady state that ends it
    localparam int SW_DONE_D = SWITCH_CYCLES;
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(SWITCH_CYCLES);
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

    // fixed capability word
    localparam logic [REG_W-1:0] CAP_WORD = {CAP_IND_P, CAP_QUAD_P, CAP_PTP_P, CAP_SEC_P,
                                             1'b0, CAP_DUAL_P, CAP_HIPREC_P, CAP_KEY256_P,
                                             VARIANT_BCD};

    if (VARIANT_BCD[7:4] > 4'h9 || VARIANT_BCD[3:0] > 4'h9) begin : g_bad_bcd
        $error("variant suffix is not a bcd number");
    end
    if (SWITCH_CYCLES < 1) begin : g_bad_cnt
        $error("switchover time shorter than one clock");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [REG_W-1:0] rdata;
        logic [IRQ_N-1:0] irq_en;
        logic [IRQ_N-1:0] irq_pend;
        logic             start_en;
        logic             adv;
        logic             force_en;
        prr_ring_t        ring;
        logic [CNT_W-1:0] cnt;
        logic             link_q;
    } prr_regs_state_t;

    prr_regs_state_t r_reg;
    prr_regs_state_t r_next;

    logic [REG_W-1:0] rnd;
    logic [2:0]       line_s;
    logic             link_s;
    logic             role_s;
    logic             lp_adv_s;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // address decode, used for every register
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] idx);
        hit = (a == {idx[ADDR_W-3:0], 2'b00});
    endfunction

    prr_sync #(
        .W (3)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({link_up, aneg_master, link_partner_adv}),
        .q       (line_s)
    );
    assign link_s   = line_s[2];
    assign role_s   = line_s[1];
    assign lp_adv_s = line_s[0];

    prr_entropy u_ent (
        .pclk    (pclk),
        .presetn (presetn),
        .rnd     (rnd)
    );

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic             setup;
    logic             access;
    logic             wr;
    logic             mapped;
    logic             in_transit;
    logic             steady;
    logic             go_req;
    logic             go_ok;
    logic             done;
    logic [IRQ_N-1:0] ev_all;
    logic [IRQ_N-1:0] rd_clr;
    logic [REG_W-1:0] ring_word;

    // zero-wait slave: setup captures read data, access completes
    always_comb begin
        setup  = psel & ~penable;
        access = psel & penable;
        wr     = access & pwrite;
        mapped = hit(paddr, IDX_CAP) | hit(paddr, IDX_ENT) | hit(paddr, IDX_IEN)
               | hit(paddr, IDX_IPEND) | hit(paddr, IDX_RING);
    end

    assign pready  = access;
    assign pslverr = access & ~mapped;
    assign prdata  = {16'h0000, r_reg.rdata};

    // ring word as read back, reserved bits zero
    always_comb begin
        ring_word                            = '0;
        ring_word[RING_START_EN]             = r_reg.start_en;
        ring_word[RING_ADV]                  = r_reg.adv;
        ring_word[RING_LP_ADV]               = lp_adv_s;
        ring_word[RING_FORCE]                = r_reg.force_en;
        ring_word[RING_ST_HI:RING_ST_LO]     = prr_ring_code(r_reg.ring);
        ring_word[RING_GO]                   = in_transit;
    end

    // ------------------------------------------------------------
    // switchover decisions
    // ------------------------------------------------------------
    // start only from a steady state with link up; a request while busy is
    // dropped silently because the sequence cannot be restarted midway
    always_comb begin
        in_transit = (r_reg.ring == RING_S2M) | (r_reg.ring == RING_M2S);
        steady     = ~in_transit;
        go_req     = wr & hit(paddr, IDX_RING) & pstrb[0] & pwdata[RING_GO];
        go_ok      = go_req & steady & r_reg.link_q & link_s & r_reg.start_en
                   & (r_reg.force_en | (r_reg.adv & lp_adv_s));
        done       = in_transit & (r_reg.cnt == CNT_ONE) & link_s;
        ev_all     = irq_event;
        ev_all[IRQ_RING_DONE] = irq_event[IRQ_RING_DONE] | done;
        rd_clr     = (access & ~pwrite & hit(paddr, IDX_IPEND)) ? r_reg.rdata[IRQ_N-1:0] : '0;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        r_next        = r_reg;
        r_next.link_q = link_s;

        // read data captured in setup so clear-on-read knows what was shown
        if (setup && !pwrite) begin
            if (hit(paddr, IDX_CAP)) begin
                r_next.rdata = CAP_WORD;
            end else if (hit(paddr, IDX_ENT)) begin
                r_next.rdata = rnd;
            end else if (hit(paddr, IDX_IEN)) begin
                r_next.rdata = {5'b00000, r_reg.irq_en};
            end else if (hit(paddr, IDX_IPEND)) begin
                r_next.rdata = {5'b00000, r_reg.irq_pend};
            end else if (hit(paddr, IDX_RING)) begin
                r_next.rdata = ring_word;
            end else begin
                r_next.rdata = '0;
            end
        end

        // enable register, byte lanes honoured
        if (wr && hit(paddr, IDX_IEN)) begin
            if (pstrb[0]) begin
                r_next.irq_en[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
                r_next.irq_en[IRQ_N-1:8] = pwdata[IRQ_N-1:8];
            end
        end

        // pending: only bits that were returned are cleared, a new event wins
        r_next.irq_pend = (r_reg.irq_pend & ~rd_clr) | (ev_all & r_reg.irq_en);

        // ring control bits
        if (wr && hit(paddr, IDX_RING) && pstrb[1]) begin
            r_next.start_en = pwdata[RING_START_EN];
            r_next.adv      = pwdata[RING_ADV];
            r_next.force_en = pwdata[RING_FORCE];
        end

        // ring sequence
        if (!link_s) begin
            r_next.ring = RING_SLAVE;
            r_next.cnt  = '0;
        end else if (!r_reg.link_q) begin
            r_next.ring = role_s ? RING_MASTER : RING_SLAVE;
            r_next.cnt  = '0;
        end else begin
            case (r_reg.ring)
                RING_SLAVE: begin
                    if (go_ok) begin
                        r_next.ring = RING_S2M;
                        r_next.cnt  = CNT_LOAD;
                    end
                end
                RING_MASTER: begin
                    if (go_ok) begin
                        r_next.ring = RING_M2S;
                        r_next.cnt  = CNT_LOAD;
                    end
                end
                RING_S2M: begin
                    r_next.cnt = r_reg.cnt - CNT_ONE;
                    if (done) begin
                        r_next.ring = RING_MASTER;
                    end
                end
                RING_M2S: begin
                    r_next.cnt = r_reg.cnt - CNT_ONE;
                    if (done) begin
                        r_next.ring = RING_SLAVE;
                    end
                end
                default: begin
                    r_next.ring = RING_SLAVE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg.rdata    <= '0;
            r_reg.irq_en   <= IRQ_RESET;
            r_reg.irq_pend <= IRQ_RESET;
            r_reg.start_en <= 1'b0;
            r_reg.adv      <= 1'b0;
            r_reg.force_en <= 1'b0;
            r_reg.ring     <= RING_SLAVE;
            r_reg.cnt      <= '0;
            r_reg.link_q   <= 1'b0;
        end else begin
            r_reg <= r_next;
        end
    end

    // status outputs straight from state flops
    assign timing_role      = prr_ring_code(r_reg.ring);
    assign ring_switch_busy = in_transit;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    cap_word_a: assert property (
        (access && !pwrite && hit(paddr, IDX_CAP)) |-> (prdata[REG_W-1:0] == CAP_WORD)
        && !prdata[CAP_RSV])
        else $error("capability word wrong");

    ien_write_a: assert property (
        (wr && hit(paddr, IDX_IEN) && pstrb[1:0] == 2'b11)
        |=> (r_reg.irq_en == $past(pwdata[IRQ_N-1:0])))
        else $error("enable write not stored");

    pend_clear_a: assert property (
        (access && !pwrite && hit(paddr, IDX_IPEND))
        |=> ((r_reg.irq_pend & $past(r_reg.rdata[IRQ_N-1:0]) & ~$past(irq_event | {6'b0, done, 4'b0})) == '0))
        else $error("pending bit not cleared by read");

    pend_gate_a: assert property (
        ##1 ((r_reg.irq_pend & ~$past(r_reg.irq_pend) & ~($past(ev_all) & $past(r_reg.irq_en))) == '0))
        else $error("pending set without enabled event");

    done_irq_a: assert property (
        (done && r_reg.irq_en[IRQ_RING_DONE]) |=> r_reg.irq_pend[IRQ_RING_DONE])
        else $error("switchover completion not flagged");

    // an accepted start runs the full countdown before the role flips
    switch_seq_a: assert property (
        (go_ok && r_reg.ring == RING_SLAVE) |=> (timing_role == ST_S2M && ring_switch_busy)
        ##SW_DONE_D (timing_role == ST_MASTER || !r_reg.link_q))
        else $error("slave to master sequence wrong");

    linkup_role_a: assert property (
        (link_s && !r_reg.link_q) |=> (timing_role == ($past(role_s) ? ST_MASTER : ST_SLAVE)))
        else $error("role at link-up wrong");

    ring_rsv_a: assert property (
        (access && !pwrite && hit(paddr, IDX_RING))
        |-> (prdata[11:6] == 6'h00 && prdata[3:1] == 3'h0 && prdata[31:16] == 16'h0000))
        else $error("ring reserved bits not zero");

    // a start while busy must not reload the counter; only the countdown runs on
    busy_drop_a: assert property (
        (go_req && in_transit && link_s && r_reg.link_q)
        |=> (r_reg.cnt == $past(r_reg.cnt) - CNT_ONE))
        else $error("start accepted while busy");

    // a lost link abandons any switchover and falls back to timing slave
    link_drop_a: assert property (
        (!link_s) |=> (timing_role == ST_SLAVE && !ring_switch_busy))
        else $error("ring state kept after link loss");

endmodule // prr_regs

// File: prr_sync.sv
// two-flop level synchroniser for inputs from another domain
`timescale 1ns/10ps
module prr_sync import prr_pkg::*; #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } prr_sync_state_t;

    prr_sync_state_t r_reg;
    prr_sync_state_t r_next;

    // first stage is read only by the second stage
    always_comb begin
        r_next    = r_reg;
        r_next.s1 = d;
        r_next.s2 = r_reg.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign q = r_reg.s2;
endmodule // prr_sync

// File: tb_phy_ext_id_irq_ring_regs.sv
// self-checking testbench for the extended id, irq and ring switchover register group
`timescale 1ns/10ps
module tb_phy_ext_id_irq_ring_regs import prr_pkg::*;;

    // ------------------------------------------------------------
    // build-time capability choices and derived expectations
    // ------------------------------------------------------------
    localparam bit         P_HIP = 1'b1;
    localparam bit         P_K256 = 1'b0;
    localparam logic [7:0] P_VAR = 8'h37; // arbitrary suffix value
    localparam logic [15:0] EXP_CAP = {4'hF, 1'b0, 1'b1, P_HIP, P_K256, P_VAR};
    localparam logic [7:0] A_CAP = IDX_CAP << 2;
    localparam logic [7:0] A_ENT = IDX_ENT << 2;
    localparam logic [7:0] A_IEN = IDX_IEN << 2;
    localparam logic [7:0] A_PND = IDX_IPEND << 2;
    localparam logic [7:0] A_RNG = IDX_RING << 2;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [10:0] irq_event;
    logic        link_up;
    logic        aneg_master;
    logic        link_partner_adv;
    logic [1:0]  timing_role;
    logic        ring_switch_busy;
    int          n_mismatch;
    int          checks_done;
    int          cycles;
    logic [15:0] rd;
    logic [15:0] rd2;
    logic        err;

    prr_regs #(.CAP_IND_P(1'b1), .CAP_QUAD_P(1'b1), .CAP_PTP_P(1'b1), .CAP_SEC_P(1'b1), .CAP_DUAL_P(1'b1),
               .CAP_HIPREC_P(P_HIP), .CAP_KEY256_P(P_K256), .VARIANT_BCD(P_VAR)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_event(irq_event), .link_up(link_up), .aneg_master(aneg_master),
        .link_partner_adv(link_partner_adv), .timing_role(timing_role), .ring_switch_busy(ring_switch_busy)
    );

    // ------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ceiling well above the few hundred cycles the scenarios need
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        if (n_mismatch == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer; an idle edge first so strobes never change twice in a step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata[15:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_and_id();
        apb(1'b1, A_CAP, 16'h0000, 4'h3);
        apb(1'b0, A_CAP, 16'h0000, 4'h0);
        chk("capability", rd, EXP_CAP);
        apb(1'b0, A_IEN, 16'h0000, 4'h0);
        chk("enable_reset", rd, 16'h0000);
        apb(1'b0, A_PND, 16'h0000, 4'h0);
        chk("pending_reset", rd, 16'h0000);
        apb(1'b0, A_RNG, 16'h0000, 4'h0);
        chk("ring_reset", rd, 16'h0000);
        chk("role_reset", {14'h0, timing_role}, 16'h0000);
        apb(1'b0, A_ENT, 16'h0000, 4'h0);
        rd2 = rd;
        apb(1'b0, A_ENT, 16'h0000, 4'h0);
        chk("random_moves", {15'h0, rd !== rd2}, 16'h0001);
        apb(1'b0, 8'hFC, 16'h0000, 4'h0);
        chk("unmapped_err", {15'h0, err}, 16'h0001);
    endtask

    task automatic t_enable_bits();
        apb(1'b1, A_IEN, 16'hFFFF, 4'h3);
        apb(1'b0, A_IEN, 16'h0000, 4'h0);
        chk("enable_all", rd, 16'h07FF);
        apb(1'b1, A_IEN, 16'h0000, 4'h1);
        apb(1'b0, A_IEN, 16'h0000, 4'h0);
        chk("enable_lane0", rd, 16'h0700);
    endtask

    // each source alone: pending on enable, self-clear on read, ignored when masked
    task automatic t_pending();
        for (int i = 0; i < 11; i++) begin
            apb(1'b1, A_IEN, 16'h0001 << i, 4'h3);
            irq_event <= 11'h001 << i;
            @(posedge pclk);
            irq_event <= 11'h000;
            apb(1'b0, A_PND, 16'h0000, 4'h0);
            chk("pending_set", rd, 16'h0001 << i);
            apb(1'b0, A_PND, 16'h0000, 4'h0);
            chk("pending_clear", rd, 16'h0000);
            apb(1'b1, A_IEN, 16'h0000, 4'h3);
            irq_event <= 11'h001 << i;
            @(posedge pclk);
            irq_event <= 11'h000;
            apb(1'b0, A_PND, 16'h0000, 4'h0);
            chk("pending_masked", rd, 16'h0000);
        end
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (ring_switch_busy !== 1'b0 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        chk("busy_done", {15'h0, ring_switch_busy}, 16'h0000);
    endtask

    task automatic t_ring();
        apb(1'b1, A_IEN, 16'h0010, 4'h3);
        link_up <= 1'b1;
        link_partner_adv <= 1'b1;
        idle(6);
        apb(1'b1, A_RNG, 16'h0001, 4'h3);
        apb(1'b0, A_RNG, 16'h0000, 4'h0);
        chk("start_refused", rd, 16'h2000);
        apb(1'b1, A_RNG, 16'h9000, 4'h3);
        apb(1'b1, A_RNG, 16'h9001, 4'h3);
        apb(1'b0, A_RNG, 16'h0000, 4'h0);
        chk("to_master", rd, 16'hB021);
        apb(1'b1, A_RNG, 16'h9001, 4'h3);
        wait_idle();
        apb(1'b0, A_RNG, 16'h0000, 4'h0);
        chk("is_master", rd, 16'hB030);
        chk("role_master", {14'h0, timing_role}, 16'h0003);
        apb(1'b0, A_PND, 16'h0000, 4'h0);
        chk("switch_irq", rd, 16'h0010);
        apb(1'b1, A_RNG, 16'hC001, 4'h3);
        apb(1'b0, A_RNG, 16'h0000, 4'h0);
        chk("to_slave", rd, 16'hE011);
        wait_idle();
        apb(1'b0, A_RNG, 16'h0000, 4'h0);
        chk("is_slave", rd, 16'hE000);
        apb(1'b0, A_PND, 16'h0000, 4'h0);
        chk("switch_irq2", rd, 16'h0010);
        // relink with a negotiated master role
        link_up <= 1'b0;
        idle(6);
        aneg_master <= 1'b1;
        link_up <= 1'b1;
        idle(6);
        chk("role_aneg", {14'h0, timing_role}, 16'h0003);
        apb(1'b0, A_RNG, 16'h0000, 4'h0);
        chk("status_aneg", rd & 16'h0030, 16'h0030);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        n_mismatch = 0;
        checks_done = 0;
        cycles = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        irq_event = 11'h000;
        link_up = 1'b0;
        aneg_master = 1'b0;
        link_partner_adv = 1'b0;
        idle(8);
        presetn <= 1'b1;
        t_reset_and_id();
        t_enable_bits();
        t_pending();
        t_ring();
        give_verdict();
    end

endmodule // tb_phy_ext_id_irq_ring_regs
